// ==== spisl_params.svh ====
// Overview of operation
// R1: Master gap from gap field and phase
// R2: Fault detect on: select pin is fault input
// R3: Fault detect off: pin follows output enable
// R4: Slave mode: select pin is select input
// R5: Fault disable bit acts only in master
// R6: Done flag set when byte completes
// R7: Data writes ignored while done flag set
// R8: Interrupt on done, overrun, fault if enabled
// R9: Write collision sets sticky collision flag
// R10: Overrun sets sticky overrun flag
// R11: Master select pin low sets fault flag
// R12: Data write loads shifter, master starts byte
// R13: Data read returns receive buffer
// R14: Mode fault clears master and port enable
// R15: Auto select low during transfer, high idle
// R16: Phase picks first or second sampling edge
// R17: Collision keeps current byte, drops new
// R18: Reserved bits read zero, writes ignored
`ifndef SPISL_PARAMS_SVH
`define SPISL_PARAMS_SVH
`define SPISL_OFF_CTRL 8'hF2
`define SPISL_OFF_GAP 8'hF3
`define SPISL_OFF_STAT 8'hF4
`define SPISL_OFF_DATA 8'hF5
`define SPISL_OFF_MASK 8'hF6
`define SPISL_OFF_IRQEN 8'hF7
`define SPISL_RST_8 8'h00
`define SPISL_CTRL_SOE 7
`define SPISL_CTRL_EN 6
`define SPISL_CTRL_MST 4
`define SPISL_CTRL_PHA 2
`define SPISL_CTRL_WMASK 8'hD7
`define SPISL_GAP_WMASK 8'h03
`define SPISL_MASK_WMASK 8'hB0
`define SPISL_ST_DONE 7
`define SPISL_ST_WRITE_COLLISION_FLAG 6
`define SPISL_ST_OVF 5
`define SPISL_ST_MODE_FAULT_FLAG 4
`define SPISL_ST_DIS 3
`define SPISL_IE_PORT 0
`define SPISL_IE_GLOB 1
`define SPISL_LAST_BIT 3'h7
`define SPISL_LAST_HALF 4'hF
`endif

// ==== spisl_pkg.sv ====
package spisl_pkg;
    typedef enum logic [1:0] {
        SPISL_IDLE = 2'b00,
        SPISL_SHIFT = 2'b01,
        SPISL_GAP = 2'b11
    } spisl_state_t;
    typedef logic [7:0] spisl_byte_t;
endpackage

// ==== spisl_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "spisl_params.svh"
module spisl_top #(
    parameter int DATA_W = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire spisl_pkg::spisl_byte_t addr,
    input wire spisl_pkg::spisl_byte_t wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output var spisl_pkg::spisl_byte_t rdata,
    input wire logic sclk_in,
    output var logic sclk_out,
    output var logic sclk_oe_n,
    input wire logic mosi_in,
    output wire logic mosi_out,
    output var logic mosi_oe_n,
    input wire logic miso_in,
    output wire logic miso_out,
    output var logic miso_oe_n,
    input wire logic ss_n_in,
    output var logic ss_n_out,
    output var logic ss_oe_n,
    output var logic irq
);
    import spisl_pkg::*;

    if (DATA_W != 8) begin : g_chk
        $error("spisl_top serves only 8-bit data");
    end

    logic [7:0] ctrl_q, gap_q, mask_q, irqen_q, rxbuf_q;
    logic done_q, write_collision_flag_q, ovf_q, mode_fault_flag_q, dis_q;
    logic [DATA_W-1:0] sh_q;
    logic out_q, sclk_q, slv_prev_q;
    spisl_state_t state_q;
    logic [3:0] div_q, hcnt_q;
    logic [2:0] bcnt_q, gcnt_q;
    logic [3:0] sync1_q, sync2_q;
    logic sclk_prev_q;

    // Pin synchronisers: sclk, mosi, miso, select
    wire [3:0] pins_raw = {ss_n_in, miso_in, mosi_in, sclk_in};
    genvar gi;
    for (gi = 0; gi < 4; gi++) begin : g_sync
        // Select pin idles high, the others low
        localparam logic SYNC_IDLE = (gi == 3);
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                sync1_q[gi] <= SYNC_IDLE;
                sync2_q[gi] <= SYNC_IDLE;
            end else begin
                sync1_q[gi] <= pins_raw[gi];
                sync2_q[gi] <= sync1_q[gi];
            end
        end
    end
    wire sclk_s = sync2_q[0];
    wire mosi_s = sync2_q[1];
    wire miso_s = sync2_q[2];
    wire ss_lo = ~sync2_q[3];

    // Mode and select pin decode
    wire master = ctrl_q[`SPISL_CTRL_MST];
    wire port_en = ctrl_q[`SPISL_CTRL_EN];
    wire pha = ctrl_q[`SPISL_CTRL_PHA];
    wire mf_watch = port_en & master & ~dis_q; // R2 R5
    wire ss_auto = master & dis_q & ctrl_q[`SPISL_CTRL_SOE]; // R3
    wire mode_fault = mf_watch & ss_lo; // R11
    wire slv_act = port_en & ~master & ss_lo; // R4
    wire slv_start = slv_act & ~slv_prev_q;

    // Bus decode
    wire sel_ctrl = addr == `SPISL_OFF_CTRL;
    wire sel_gap = addr == `SPISL_OFF_GAP;
    wire sel_stat = addr == `SPISL_OFF_STAT;
    wire sel_data = addr == `SPISL_OFF_DATA;
    wire sel_mask = addr == `SPISL_OFF_MASK;
    wire sel_irqen = addr == `SPISL_OFF_IRQEN;
    wire wr_data = wr_en & sel_data;
    wire wr_stat = wr_en & sel_stat;
    wire [7:0] stat_rd = {done_q, write_collision_flag_q, ovf_q, mode_fault_flag_q, dis_q, 3'h0};
    wire [7:0] rd_mux = sel_ctrl ? ctrl_q :
                        sel_gap ? gap_q : // R18
                        sel_stat ? stat_rd :
                        sel_data ? rxbuf_q : // R13
                        sel_mask ? mask_q :
                        sel_irqen ? irqen_q : `SPISL_RST_8;

    // Serial clock divider and edges
    wire [3:0] half_lim = 4'((5'h1 << ctrl_q[1:0]) - 5'h1);
    wire running = state_q != SPISL_IDLE;
    wire tick = running & (div_q == half_lim);
    wire m_shift = master & (state_q == SPISL_SHIFT) & tick;
    wire edge_rise = master ? (m_shift & ~sclk_q) :
                     (slv_act & sclk_s & ~sclk_prev_q);
    wire edge_fall = master ? (m_shift & sclk_q) :
                     (slv_act & ~sclk_s & sclk_prev_q);
    wire samp = pha ? edge_fall : edge_rise; // R16
    wire shout = pha ? edge_rise : edge_fall; // R16
    wire din = master ? miso_s : mosi_s;
    wire [DATA_W-1:0] sh_in = {sh_q[DATA_W-2:0], din};
    wire shift_end = m_shift & (hcnt_q == `SPISL_LAST_HALF);
    wire slv_byte = ~master & samp & (bcnt_q == `SPISL_LAST_BIT);
    wire rx_load = shift_end | slv_byte; // R6
    wire [DATA_W-1:0] rx_val = samp ? sh_in : sh_q;
    wire [2:0] gap_lim = {1'b0, gap_q[1:0]} + {2'h0, pha}; // R1
    wire gap_end = (state_q == SPISL_GAP) & tick & (gcnt_q == gap_lim);

    // Data write outcome
    wire busy = running | slv_act;
    wire wr_ok = wr_data & ~done_q & ~busy; // R7
    wire wr_coll = wr_data & ~done_q & busy; // R9 R17
    wire m_start = wr_ok & master & port_en; // R12

    // Flag next values, set wins over clear
    wire clr = wr_stat;
    wire done_d = rx_load | (done_q & ~(clr & wdata[`SPISL_ST_DONE]));
    wire write_collision_flag_d = wr_coll | (write_collision_flag_q & ~(clr & wdata[`SPISL_ST_WRITE_COLLISION_FLAG]));
    wire ovf_set = slv_byte & done_q; // R10
    wire ovf_d = ovf_set | (ovf_q & ~(clr & wdata[`SPISL_ST_OVF]));
    wire mode_fault_flag_d = mode_fault | (mode_fault_flag_q & ~(clr & wdata[`SPISL_ST_MODE_FAULT_FLAG]));
    wire irq_d = ((done_q & mask_q[`SPISL_ST_DONE]) |
                  (ovf_q & mask_q[`SPISL_ST_OVF]) |
                  (mode_fault_flag_q & mask_q[`SPISL_ST_MODE_FAULT_FLAG])) &
                 irqen_q[`SPISL_IE_PORT] & irqen_q[`SPISL_IE_GLOB]; // R8

    // Register file
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `SPISL_RST_8;
            gap_q <= `SPISL_RST_8;
            mask_q <= `SPISL_RST_8;
            irqen_q <= `SPISL_RST_8;
            dis_q <= 1'b0;
        end else begin
            if (wr_en & sel_ctrl) begin
                ctrl_q <= wdata & `SPISL_CTRL_WMASK;
            end
            if (mode_fault) begin
                ctrl_q[`SPISL_CTRL_MST] <= 1'b0; // R14
                ctrl_q[`SPISL_CTRL_EN] <= 1'b0; // R14
            end
            if (wr_en & sel_gap) begin
                gap_q <= wdata & `SPISL_GAP_WMASK; // R18
            end
            if (wr_en & sel_mask) begin
                mask_q <= wdata & `SPISL_MASK_WMASK;
            end
            if (wr_en & sel_irqen) begin
                irqen_q <= {6'h00, wdata[1:0]};
            end
            if (wr_stat) begin
                dis_q <= wdata[`SPISL_ST_DIS];
            end
        end
    end

    // Flags, read data and interrupt
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            write_collision_flag_q <= 1'b0;
            ovf_q <= 1'b0;
            mode_fault_flag_q <= 1'b0;
            rxbuf_q <= `SPISL_RST_8;
            rdata <= `SPISL_RST_8;
            irq <= 1'b0;
        end else begin
            done_q <= done_d;
            write_collision_flag_q <= write_collision_flag_d;
            ovf_q <= ovf_d;
            mode_fault_flag_q <= mode_fault_flag_d;
            if (rx_load & ~ovf_set) begin
                rxbuf_q <= rx_val;
            end
            rdata <= rd_en ? rd_mux : `SPISL_RST_8;
            irq <= irq_d;
        end
    end

    // Sequencer: idle, shift, gap
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SPISL_IDLE;
            div_q <= 4'h0;
            hcnt_q <= 4'h0;
            gcnt_q <= 3'h0;
            sclk_q <= 1'b0;
        end else if (mode_fault | (running & ~(port_en & master))) begin
            state_q <= SPISL_IDLE;
            sclk_q <= 1'b0;
        end else begin
            div_q <= (tick | ~running) ? 4'h0 : div_q + 4'h1;
            if (m_start) begin
                state_q <= SPISL_SHIFT;
                hcnt_q <= 4'h0;
            end else if (shift_end) begin
                state_q <= SPISL_GAP;
                gcnt_q <= 3'h0;
            end else if (gap_end) begin
                state_q <= SPISL_IDLE;
            end else if (tick) begin
                hcnt_q <= hcnt_q + 4'h1;
                gcnt_q <= gcnt_q + 3'h1;
            end
            if (m_shift) begin
                sclk_q <= ~sclk_q;
            end
        end
    end

    // Shifter and serial out
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sh_q <= '0;
            bcnt_q <= 3'h0;
            out_q <= 1'b0;
            sclk_prev_q <= 1'b0;
            slv_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            slv_prev_q <= slv_act;
            if (wr_ok) begin
                sh_q <= wdata; // R12
                out_q <= wdata[DATA_W-1];
                bcnt_q <= 3'h0;
            end else if (samp) begin
                sh_q <= sh_in;
                bcnt_q <= bcnt_q + 3'h1;
            end else if (~master & ~slv_act) begin
                bcnt_q <= 3'h0;
            end
            if (shout | slv_start) begin
                out_q <= sh_q[DATA_W-1];
            end
        end
    end

    // Pin drivers
    assign mosi_out = out_q;
    assign miso_out = out_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sclk_out <= 1'b0;
            sclk_oe_n <= 1'b1;
            mosi_oe_n <= 1'b1;
            miso_oe_n <= 1'b1;
            ss_n_out <= 1'b1;
            ss_oe_n <= 1'b1;
        end else begin
            sclk_out <= sclk_q;
            sclk_oe_n <= ~(port_en & master);
            mosi_oe_n <= ~(port_en & master);
            miso_oe_n <= ~slv_act;
            ss_n_out <= ~running; // R15
            ss_oe_n <= ~(port_en & ss_auto); // R3 R4
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_ignored_write;
        done_q && wr_data && state_q == SPISL_IDLE;
    endsequence
    sequence s_fault_seen;
        mode_fault ##1 mode_fault_flag_q;
    endsequence

    a_done_blocks_write: assert property (s_ignored_write |=> // R7
        state_q == SPISL_IDLE && $stable(sh_q))
        else $error("write taken while done flag set");
    a_fault_disables: assert property (mode_fault |-> s_fault_seen ##0 // R11
        (!ctrl_q[`SPISL_CTRL_MST] && !ctrl_q[`SPISL_CTRL_EN])) // R14
        else $error("mode fault not handled");
    a_collision_flag: assert property (wr_coll |=> write_collision_flag_q) // R9
        else $error("collision flag not set");
    a_collision_keep: assert property ( // R17
        wr_coll && state_q == SPISL_SHIFT && !samp && !mode_fault
        |=> $stable(sh_q))
        else $error("collision overwrote shifter");
    a_overrun_flag: assert property (ovf_set |=> ovf_q && $stable(rxbuf_q)) // R10
        else $error("overrun not flagged");
    a_irq_follows: assert property ((done_q && mask_q[`SPISL_ST_DONE] && // R8
        irqen_q[`SPISL_IE_PORT] && irqen_q[`SPISL_IE_GLOB]) |=> irq)
        else $error("interrupt not raised");
    a_irq_gated: assert property (!irqen_q[`SPISL_IE_GLOB] |=> !irq) // R8
        else $error("interrupt without global enable");
    a_master_start: assert property (m_start && !mode_fault |=> // R12
        state_q == SPISL_SHIFT)
        else $error("master write did not start");
    a_read_buffer: assert property (rd_en && sel_data |=> // R13
        rdata == $past(rxbuf_q))
        else $error("data read not from buffer");
    a_done_on_byte: assert property (rx_load |=> done_q) // R6
        else $error("done flag missing");
    a_gap_bound: assert property (state_q == SPISL_GAP |-> // R1
        gcnt_q <= gap_lim)
        else $error("gap overran its length");
    a_select_auto: assert property (running && ss_auto |-> ##1 !ss_n_out) // R15
        else $error("select not low in transfer");
    a_slave_input: assert property (!master |=> ss_oe_n) // R4 R5
        else $error("select driven in slave mode");
    a_reserved_zero: assert property (rd_en && sel_gap |=> // R18
        rdata[7:2] == 6'h00)
        else $error("reserved gap bits not zero");
    a_sample_edge: assert property (m_shift && hcnt_q == 4'h0 |-> // R16
        samp == !pha)
        else $error("first edge sampling wrong");
endmodule
`default_nettype wire

// ==== spisl_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module spisl_far_model #(
    parameter logic [7:0] REPLY = 8'h3C
) (
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    output var logic miso,
    output var logic [7:0] rx
);
    logic [7:0] tx;
    logic last;
    initial begin
        miso = 1'b0;
        rx = 8'h00;
        tx = REPLY;
        last = 1'b0;
    end
    // First bit ready before the first edge
    always @(negedge ss_n) begin
        tx = REPLY;
        miso = REPLY[7];
        last = REPLY[7];
    end
    // Sample on first edge
    always @(posedge sclk) begin
        if (!ss_n) begin
            rx = {rx[6:0], mosi};
        end
    end
    always @(negedge sclk) begin
        if (!ss_n) begin
            tx = {tx[6:0], 1'b0};
            miso = tx[7];
            last = tx[7];
        end
    end
    // Released line shows inverse of last bit
    always @(posedge ss_n) begin
        miso = ~last;
    end
endmodule
`default_nettype wire

// ==== tb_spi_status_and_select_logic.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_spi_status_and_select_logic;
    import spisl_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    spisl_byte_t addr = 8'h00;
    spisl_byte_t wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic sclk_in = 1'b0;
    logic mosi_in = 1'b0;
    logic ss_n_in = 1'b1;
    spisl_byte_t rdata;
    logic [7:0] rx;
    logic sclk_out, sclk_oe_n, mosi_out, mosi_oe_n, miso_in, miso_out;
    logic miso_oe_n, ss_n_out, ss_oe_n, irq;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    always #2 clk_sys = ~clk_sys;
    spisl_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
        .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
        .miso_in(miso_in), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
        .ss_n_in(ss_n_in), .ss_n_out(ss_n_out), .ss_oe_n(ss_oe_n),
        .irq(irq));
    spisl_far_model i_far (.sclk(sclk_out), .ss_n(ss_n_out),
        .mosi(mosi_out), .miso(miso_in), .rx(rx));
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            $display("unexpected at %0t: timeout", $time);
            close_out;
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e, string m);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h", $time, m, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e, string m);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk(rdata, e, m);
        @(posedge clk_sys);
    endtask
    task automatic t_regs;
        rchk(8'hF3, 8'h00, "gap reset");
        rchk(8'hF4, 8'h00, "status reset");
        rchk(8'hF5, 8'h00, "data reset");
        wr(8'hF3, 8'hFF);
        rchk(8'hF3, 8'h03, "gap reserved");
        wr(8'hF4, 8'hF8);
        rchk(8'hF4, 8'h08, "status reserved");
        wr(8'hF3, 8'h00);
        $display("test regs finished");
    endtask
    task automatic t_xfer;
        int lo;
        lo = 0;
        wr(8'hF2, 8'hD3);
        @(posedge clk_sys);
        chk({7'h00, ss_oe_n}, 8'h00, "select out enable");
        chk({6'h00, sclk_oe_n, mosi_oe_n}, 8'h00, "master drives");
        wr(8'hF5, 8'hA5);
        wr(8'hF5, 8'h5A);
        repeat (300) begin
            @(posedge clk_sys);
            if (ss_n_out === 1'b0) lo++;
        end
        chk(8'(lo > 100), 8'h01, "select low in byte");
        chk({7'h00, ss_n_out}, 8'h01, "select high idle");
        chk(rx, 8'hA5, "byte sent");
        rchk(8'hF4, 8'hC8, "done and collision");
        rchk(8'hF5, 8'h3C, "read buffer");
        wr(8'hF5, 8'h77);
        repeat (20) @(posedge clk_sys);
        chk({7'h00, ss_n_out}, 8'h01, "write while done");
        rchk(8'hF4, 8'hC8, "no flag change");
        wr(8'hF4, 8'hC8);
        rchk(8'hF4, 8'h08, "flags cleared");
        $display("test xfer finished");
    endtask
    task automatic t_gap;
        int base, lo;
        base = 0;
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 4; c++) begin
                lo = 0;
                wr(8'hF2, 8'hD1 | 8'(p << 2));
                wr(8'hF3, 8'(c));
                wr(8'hF5, 8'h00);
                repeat (120) begin
                    @(posedge clk_sys);
                    if (ss_n_out === 1'b0) lo++;
                end
                wr(8'hF4, 8'h88);
                if (p == 0 && c == 0) base = lo;
                chk(8'(lo - base), 8'((c + p) * 2), "gap length");
            end
        end
        $display("test gap finished");
    endtask
    task automatic t_fault;
        wr(8'hF4, 8'h00);
        wr(8'hF2, 8'hD0);
        wr(8'hF6, 8'hB0);
        wr(8'hF7, 8'h03);
        chk({7'h00, ss_oe_n}, 8'h01, "select is input");
        ss_n_in <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rchk(8'hF4, 8'h10, "mode fault");
        rchk(8'hF2, 8'h80, "port disabled");
        chk({7'h00, irq}, 8'h01, "irq on fault");
        wr(8'hF7, 8'h01);
        repeat (2) @(posedge clk_sys);
        chk({7'h00, irq}, 8'h00, "irq global off");
        ss_n_in <= 1'b1;
        wr(8'hF4, 8'h10);
        rchk(8'hF4, 8'h00, "fault cleared");
        $display("test fault finished");
    endtask
    task automatic send(input logic [7:0] b);
        ss_n_in <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk({7'h00, miso_oe_n}, 8'h00, "slave drives reply");
        for (int i = 7; i >= 0; i--) begin
            mosi_in <= b[i];
            repeat (4) @(posedge clk_sys);
            sclk_in <= 1'b1;
            repeat (4) @(posedge clk_sys);
            sclk_in <= 1'b0;
        end
        repeat (8) @(posedge clk_sys);
        ss_n_in <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic t_slave;
        wr(8'hF2, 8'hC0);
        @(posedge clk_sys);
        chk({7'h00, ss_oe_n}, 8'h01, "slave select in");
        chk({6'h00, sclk_oe_n, mosi_oe_n}, 8'h03, "slave inputs");
        send(8'h96);
        rchk(8'hF4, 8'h80, "slave done no fault");
        rchk(8'hF5, 8'h96, "slave byte");
        send(8'h69);
        rchk(8'hF4, 8'hA0, "overrun");
        rchk(8'hF5, 8'h96, "buffer kept");
        wr(8'hF7, 8'h03);
        @(posedge clk_sys);
        chk({7'h00, irq}, 8'h01, "irq on done");
        wr(8'hF4, 8'hF0);
        @(posedge clk_sys);
        chk({7'h00, irq}, 8'h00, "irq cleared");
        $display("test slave finished");
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_regs;
        t_xfer;
        t_gap;
        t_fault;
        t_slave;
        close_out;
    end
endmodule
`default_nettype wire
